//--- rtl/trig_in_pkg.sv
// Constants shared by the trigger input debounce and select block.
// Behaviour
// - Accept input change only after stable time
// - Stability time in 3.2 ns steps, default 1 us
// - Accepted change is delayed by stability time
// - One stability time for all inputs, last write wins
// - Main level register shows eight main inputs
// - Front level register shows four front inputs
// - Select one of twelve inputs, main 0 at reset
// - External mode: selected input drives image trigger
// - Other modes: selected input feeds statistics only
// - Programmable active level, high active at reset
package trig_in_pkg;

  localparam int unsigned MAIN_INPUTS = 8;
  localparam int unsigned FRONT_INPUTS = 4;
  localparam int unsigned ALL_INPUTS = MAIN_INPUTS + FRONT_INPUTS;

  // Register byte offsets on the APB.
  localparam logic [7:0] STAB_TIME_OFS = 8'h00;
  localparam logic [7:0] MAIN_LEVEL_OFS = 8'h04;
  localparam logic [7:0] FRONT_LEVEL_OFS = 8'h08;
  localparam logic [7:0] SELECT_OFS = 8'h0c;
  localparam logic [7:0] CONTROL_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // Stability time: one step is 0.0032 us, full scale 65535 steps is 209.712 us.
  localparam int unsigned STAB_TIME_W = 16;
  localparam int unsigned STEP_PS = 3200;
  localparam int unsigned CLK_PERIOD_PS = 40000;
  // Half steps added per clock: 25, so the comparison stays exact in integers.
  localparam int unsigned HALF_STEPS_PER_CLK = (2 * CLK_PERIOD_PS) / STEP_PS;
  // 1.0 us is 312.5 steps; rounded up so the time is never shorter than asked.
  localparam logic [15:0] STAB_TIME_RST = 16'h0139;

  // Control register fields.
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned MODE_W = 2;
  localparam int unsigned ACTIVE_LOW_BIT = 2;
  localparam logic [3:0] SELECT_RST = 4'h0;
  localparam logic [3:0] SELECT_MAX = 4'hb;

  typedef enum logic [1:0] {
    MODE_GENERATOR = 2'h0,
    MODE_EXTERNAL = 2'h1,
    MODE_SOFTWARE = 2'h2,
    MODE_SYNCHRONIZED = 2'h3
  } trigger_operating_mode_t;

  localparam logic [31:0] APB_READ_ZERO = 32'h0000_0000;

endpackage : trig_in_pkg

//--- rtl/trigger_input_debounce_select.sv
// Debounces main and front digital inputs and selects the image trigger source.
`timescale 1ns/1ns
`default_nettype none
module trigger_input_debounce_select
  import trig_in_pkg::*;
#(
  parameter int unsigned ACC_W = 18
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [7:0] main_inputs_in,
  input wire logic [3:0] front_inputs_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [11:0] debounced_levels_out,
  output logic image_trigger_out,
  output logic statistics_input_out,
  output logic [1:0] trigger_operating_mode_out
);

  // Register state.
  logic [STAB_TIME_W-1:0] input_stability_time_r, input_stability_time_nxt;
  logic [3:0] trigger_input_select_r, trigger_input_select_nxt;
  logic [1:0] trigger_operating_mode_r, trigger_operating_mode_nxt;
  logic input_active_level_r, input_active_level_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic image_trigger_r, image_trigger_nxt;
  logic statistics_r, statistics_nxt;

  // Synchroniser and debounce state, one lane per input.
  logic [ALL_INPUTS-1:0] raw_in;
  logic [ALL_INPUTS-1:0] sync1_r, sync2_r, sync3_r;
  logic [ALL_INPUTS-1:0] db_r, db_nxt;
  logic [ACC_W-1:0] acc_r [ALL_INPUTS];
  logic [ACC_W-1:0] acc_nxt [ALL_INPUTS];
  logic [ACC_W-1:0] threshold;

  logic setup_phase, access_done, wr_en;
  logic selected_level;

  assign raw_in = {front_inputs_in, main_inputs_in};
  // The threshold is in half steps so one clock adds exactly 25 with no rounding.
  assign threshold = ACC_W'({input_stability_time_r, 1'b0});

  // Three flops: the first is metastability guard only, the last two must agree.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // The chain must stay a plain shift, or a pin change could skip the agreement check.
  a_sync_chain: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (sync2_r == $past(sync1_r)) && (sync3_r == $past(sync2_r)))
    else $error("input synchroniser chain did not shift");

  genvar gi;
  generate
    for (gi = 0; gi < ALL_INPUTS; gi++) begin : g_lane
      logic [ACC_W-1:0] acc_sum;
      // ACC_W must hold twice the largest stability time plus one clock of half steps.
      assign acc_sum = acc_r[gi] + ACC_W'(HALF_STEPS_PER_CLK);

      always_comb begin
        acc_nxt[gi] = '0;
        db_nxt[gi] = db_r[gi];
        // Any disagreement or return to the old level restarts the stable time.
        if ((sync2_r[gi] == sync3_r[gi]) && (sync3_r[gi] != db_r[gi])) begin
          if (acc_sum > threshold) begin
            db_nxt[gi] = sync3_r[gi];
          end else begin
            acc_nxt[gi] = acc_sum;
          end
        end
      end

      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          acc_r[gi] <= '0;
          db_r[gi] <= 1'b0;
        end else begin
          acc_r[gi] <= acc_nxt[gi];
          db_r[gi] <= db_nxt[gi];
        end
      end

      // A debounced level only moves to a level the synchroniser held steadily.
      a_db_follows_sync: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (db_r[gi] != $past(db_r[gi])) |-> (db_r[gi] == $past(sync3_r[gi], 1)
          && $past(sync2_r[gi] == sync3_r[gi], 1)))
        else $error("debounced level changed without a stable input");

      // A zero stability time passes a steady change on the very next edge.
      a_zero_time_pass: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (input_stability_time_r == '0 && sync2_r[gi] == sync3_r[gi]
          && sync3_r[gi] != db_r[gi]) |=> (db_r[gi] == $past(sync3_r[gi])))
        else $error("zero stability time did not pass the change at once");

      // Up to twelve steps fit inside one clock, so only from thirteen steps on
      // must a change have been counted for at least one clock before it is taken.
      a_min_hold: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (db_r[gi] != $past(db_r[gi]) && $past(input_stability_time_r) > 16'h000c)
          |-> ($past(acc_r[gi]) != '0))
        else $error("input accepted before the stability time ran out");

      // A disagreement of the last two flops or a return to the old level clears the count.
      a_restart_count: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !(sync2_r[gi] == sync3_r[gi] && sync3_r[gi] != db_r[gi]) |=> (acc_r[gi] == '0))
        else $error("stability count survived an unstable input");

      // The count never rests above the threshold it was last compared with.
      // A lower time written mid-count is then met on the following edge.
      a_acc_bound: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        acc_r[gi] <= $past(threshold))
        else $error("stability count ran past the threshold");
    end
  endgenerate

  // Selection, active level and mode gating.
  always_comb begin
    selected_level = db_r[trigger_input_select_r];
    statistics_nxt = selected_level ^ input_active_level_r;
    image_trigger_nxt = 1'b0;
    if (trigger_operating_mode_r == MODE_EXTERNAL) begin
      image_trigger_nxt = statistics_nxt;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      image_trigger_r <= 1'b0;
      statistics_r <= 1'b0;
    end else begin
      image_trigger_r <= image_trigger_nxt;
      statistics_r <= statistics_nxt;
    end
  end

  // Outside external mode the selected input reaches only the statistics path.
  a_trig_ext_only: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    image_trigger_r |-> ($past(trigger_operating_mode_r) == MODE_EXTERNAL))
    else $error("image trigger raised outside external mode");

  // In external mode both outputs carry the same conditioned level.
  a_trig_follows_sel: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ($past(trigger_operating_mode_r) == MODE_EXTERNAL)
      |-> (image_trigger_r == statistics_r))
    else $error("image trigger does not follow the selected input");

  // The active level is applied after selection, one clock behind the debounced lane.
  a_stats_polarity: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    statistics_r == ($past(db_r[trigger_input_select_r]) ^ $past(input_active_level_r)))
    else $error("statistics input has wrong level or polarity");

  // The selector refuses codes past the last front input, so it always names a source.
  a_select_range: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    trigger_input_select_r <= SELECT_MAX)
    else $error("trigger input selector left the range of inputs");

  // APB slave: read data is prepared in the setup cycle so the access phase
  // completes with zero wait states and every bus output is a flop.
  assign setup_phase = psel_in && !penable_in;
  assign access_done = psel_in && penable_in && pready_r;
  // An erroring access never writes, so a mistyped offset cannot disturb the setup.
  assign wr_en = access_done && pwrite_in && !pslverr_r;

  always_comb begin
    pready_nxt = setup_phase;
    pslverr_nxt = 1'b0;
    prdata_nxt = APB_READ_ZERO;
    input_stability_time_nxt = input_stability_time_r;
    trigger_input_select_nxt = trigger_input_select_r;
    trigger_operating_mode_nxt = trigger_operating_mode_r;
    input_active_level_nxt = input_active_level_r;
    if (setup_phase) begin
      case (paddr_in)
        STAB_TIME_OFS: prdata_nxt = 32'(input_stability_time_r);
        MAIN_LEVEL_OFS: prdata_nxt = 32'(sync3_r[MAIN_INPUTS-1:0]);
        FRONT_LEVEL_OFS: prdata_nxt = 32'(sync3_r[ALL_INPUTS-1:MAIN_INPUTS]);
        SELECT_OFS: prdata_nxt = 32'(trigger_input_select_r);
        CONTROL_OFS: prdata_nxt = 32'({input_active_level_r, trigger_operating_mode_r});
        STATUS_OFS: prdata_nxt = 32'(db_r);
        default: pslverr_nxt = 1'b1;
      endcase
      if (pwrite_in) begin
        prdata_nxt = APB_READ_ZERO;
      end
    end else if (psel_in && penable_in) begin
      pslverr_nxt = pslverr_r;
      prdata_nxt = prdata_r;
    end
    if (wr_en) begin
      case (paddr_in)
        STAB_TIME_OFS: input_stability_time_nxt = pwdata_in[STAB_TIME_W-1:0];
        SELECT_OFS: begin
          // Codes above the last front input are ignored so one source stays chosen.
          if (pwdata_in[3:0] <= SELECT_MAX) begin
            trigger_input_select_nxt = pwdata_in[3:0];
          end
        end
        CONTROL_OFS: begin
          trigger_operating_mode_nxt = pwdata_in[MODE_LSB +: MODE_W];
          input_active_level_nxt = pwdata_in[ACTIVE_LOW_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      input_stability_time_r <= STAB_TIME_RST;
      trigger_input_select_r <= SELECT_RST;
      trigger_operating_mode_r <= MODE_GENERATOR;
      input_active_level_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      input_stability_time_r <= input_stability_time_nxt;
      trigger_input_select_r <= trigger_input_select_nxt;
      trigger_operating_mode_r <= trigger_operating_mode_nxt;
      input_active_level_r <= input_active_level_nxt;
    end
  end

  // A refused select code leaves the previous source in place.
  a_select_in_range: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wr_en && paddr_in == SELECT_OFS && pwdata_in[3:0] > SELECT_MAX)
      |=> $stable(trigger_input_select_r))
    else $error("out of range select code was taken");

  // The newest write governs every lane at once.
  a_time_write: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wr_en && paddr_in == STAB_TIME_OFS)
      |=> (input_stability_time_r == $past(pwdata_in[STAB_TIME_W-1:0])))
    else $error("stability time write did not take effect");

  // Mode and active level land together from one control write.
  a_ctrl_write: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wr_en && paddr_in == CONTROL_OFS)
      |=> (trigger_operating_mode_r == $past(pwdata_in[MODE_LSB +: MODE_W])
        && input_active_level_r == $past(pwdata_in[ACTIVE_LOW_BIT])))
    else $error("control write did not take effect");

  // The level registers show the synchronised live pins, not the debounced lanes.
  a_main_read: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (setup_phase && !pwrite_in && paddr_in == MAIN_LEVEL_OFS)
      ##1 (psel_in && penable_in)
      |-> (pready_r && prdata_r == 32'($past(sync3_r[MAIN_INPUTS-1:0]))))
    else $error("main level read returned wrong data");

  a_front_read: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (setup_phase && !pwrite_in && paddr_in == FRONT_LEVEL_OFS)
      ##1 (psel_in && penable_in)
      |-> (prdata_r == 32'($past(sync3_r[ALL_INPUTS-1:MAIN_INPUTS]))))
    else $error("front level read returned wrong data");

  // Status shows the debounced lanes as the trigger logic sees them.
  a_status_read: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (setup_phase && !pwrite_in && paddr_in == STATUS_OFS)
      ##1 (psel_in && penable_in)
      |-> (prdata_r == 32'($past(db_r))))
    else $error("status read returned wrong data");

  // An address off the map must end in an error rather than a silent zero.
  a_err_unmapped: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (setup_phase && (paddr_in[1:0] != 2'h0 || paddr_in > STATUS_OFS))
      |=> (pready_r && pslverr_r))
    else $error("unmapped address did not return an error");

  // A write never puts stale read data onto the bus.
  a_write_zero: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (setup_phase && pwrite_in) |=> (prdata_r == APB_READ_ZERO))
    else $error("write access returned read data");

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign debounced_levels_out = db_r;
  assign image_trigger_out = image_trigger_r;
  assign statistics_input_out = statistics_r;
  assign trigger_operating_mode_out = trigger_operating_mode_r;

endmodule : trigger_input_debounce_select
`default_nettype wire

//--- dv/input_source_model.sv
// Bouncing signal sources that drive the twelve digital trigger inputs.
`timescale 1ns/1ns
`default_nettype none
module input_source_model (
  input wire logic mclk_in,
  input wire logic [11:0] level_in,
  input wire logic bounce_in,
  output logic [7:0] main_out,
  output logic [3:0] front_out
);
  logic [11:0] pin_r = 12'h000;
  logic [11:0] old_r = 12'h000;
  logic [11:0] mask_r = 12'h000;
  logic [2:0] chatter_r = 3'h0;
  // A real contact chatters after each change, so the new level only settles after a burst.
  always @(posedge mclk_in) begin
    old_r <= level_in;
    if (bounce_in && level_in != old_r) begin
      chatter_r <= 3'h5;
      mask_r <= level_in ^ old_r;
    end else if (chatter_r != 3'h0) begin
      chatter_r <= chatter_r - 3'h1;
    end
    pin_r <= level_in ^ ((chatter_r[0]) ? mask_r : 12'h000);
  end
  assign main_out = pin_r[7:0];
  assign front_out = pin_r[11:8];
endmodule : input_source_model
`default_nettype wire

//--- dv/test_trigger_input_debounce_select.sv
// Self-checking testbench for the trigger input debounce and select block.
`timescale 1ns/1ns
`default_nettype none
module test_trigger_input_debounce_select;
  import trig_in_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [11:0] deb;
  logic img;
  logic stat;
  logic [1:0] mode;
  logic [7:0] main_pins;
  logic [3:0] front_pins;
  logic [11:0] level = 12'h000;
  logic bounce = 1'b0;
  int err_count = 0;
  int tests_run = 0;

  trigger_input_debounce_select dut (.mclk_in(mclk), .nrst_in(nrst), .main_inputs_in(main_pins),
    .front_inputs_in(front_pins), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .debounced_levels_out(deb), .image_trigger_out(img),
    .statistics_input_out(stat), .trigger_operating_mode_out(mode));
  input_source_model source (.mclk_in(mclk), .level_in(level), .bounce_in(bounce),
    .main_out(main_pins), .front_out(front_pins));

  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Signals move by non-blocking assignment after a rising edge; pready is taken at the
  // rising edge itself, before the slave's own update at that edge lands.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_reg(input logic [7:0] addr, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'b1, addr, wd, d, e);
  endtask : wr_reg

  task automatic reg_check(input string what, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, addr, 32'h0000_0000, d, e);
    check(what, d, exp);
  endtask : reg_check

  task automatic test_reset();
    logic [31:0] d;
    logic e;
    reg_check("stability time", STAB_TIME_OFS, 32'h0000_0139);
    reg_check("select", SELECT_OFS, 32'h0000_0000);
    reg_check("control", CONTROL_OFS, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000, d, e);
    check("unmapped error", {31'h0, e}, 32'h0000_0001);
    $display("test reset done");
  endtask : test_reset

  task automatic test_levels();
    level <= 12'ha25;
    repeat (6) @(posedge mclk);
    reg_check("main levels", MAIN_LEVEL_OFS, 32'h0000_0025);
    reg_check("front levels", FRONT_LEVEL_OFS, 32'h0000_000a);
    level <= 12'h000;
    repeat (60) @(posedge mclk);
    $display("test levels done");
  endtask : test_levels

  task automatic test_debounce();
    bounce <= 1'b1;
    level <= 12'h008;
    repeat (25) @(posedge mclk);
    check("early accept", {31'h0, deb[3]}, 32'h0000_0000);
    repeat (20) @(posedge mclk);
    check("late accept", {31'h0, deb[3]}, 32'h0000_0001);
    reg_check("status levels", STATUS_OFS, 32'h0000_0008);
    bounce <= 1'b0;
    level <= 12'h009;
    repeat (10) @(posedge mclk);
    level <= 12'h008;
    repeat (45) @(posedge mclk);
    check("spike filtered", {20'h0, deb}, 32'h0000_0008);
    wr_reg(STAB_TIME_OFS, 32'h0000_0000);
    level <= 12'h000;
    repeat (10) @(posedge mclk);
    check("zero time", {20'h0, deb}, 32'h0000_0000);
    $display("test debounce done");
  endtask : test_debounce

  task automatic test_select();
    logic [1:0] m;
    logic low;
    for (int i = 0; i < 12; i++) begin
      m = i[1:0];
      low = (i >= 6);
      wr_reg(SELECT_OFS, 32'(i));
      wr_reg(CONTROL_OFS, {29'h0, low, m});
      level <= 12'h001 << i;
      repeat (10) @(posedge mclk);
      check("mode out", {30'h0, mode}, {30'h0, m});
      check("stats high", {31'h0, stat}, {31'h0, ~low});
      check("trigger high", {31'h0, img}, {31'h0, (m == MODE_EXTERNAL) & ~low});
      level <= 12'h000;
      repeat (10) @(posedge mclk);
      check("stats low", {31'h0, stat}, {31'h0, low});
      check("trigger low", {31'h0, img}, {31'h0, (m == MODE_EXTERNAL) & low});
    end
    wr_reg(SELECT_OFS, 32'h0000_000c);
    reg_check("select kept", SELECT_OFS, 32'h0000_000b);
    wr_reg(STAB_TIME_OFS, 32'h0000_ffff);
    reg_check("max time", STAB_TIME_OFS, 32'h0000_ffff);
    $display("test select done");
  endtask : test_select

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    test_reset();
    test_levels();
    test_debounce();
    test_select();
    wrap_up();
  end
endmodule : test_trigger_input_debounce_select
`default_nettype wire
